/* File: hdl/dump_consts.svh */
`ifndef DUMP_CONSTS_SVH
`define DUMP_CONSTS_SVH
`define DUMP_STAGES 3
`define DUMP_REG_W 5
`define DUMP_DATA_W 32
`define DUMP_ADDR_W 32
`endif

/* File: hdl/dump_pkg.sv */
package dump_pkg;
    typedef enum logic [1:0] {
        DUMP_OP_LOAD,
        DUMP_OP_STORE,
        DUMP_OP_XCHG,
        DUMP_OP_LADDR
    } dump_op_e;
endpackage

/* File: hdl/dump_top.sv */
// Contract
// - Three-stage data pipeline; every access walks stages 2, 1, 0.
// - Stage 2 computes address; stage 1 address phase; stage 0 reply phase.
// - Stages 0 and 1 own primary and secondary writeback latches for loads; only stage 0 has one, and it holds only an exchange's read word.
// - Address phase of one access overlaps reply phase of the previous.
// - Three clocks per access without waits; three accesses may overlap.
// - Loads and exchanges set destination scoreboard bit in the execute stage.
// - Single access latency 3 plus waits; double and exchange 4 plus waits.
// - Store and load-address skip scoreboard, take next writeback slot for source fetch.
// - Loads and exchanges waive the next slot, request one after the access.
// - Latency is 3 plus waits of this and two earlier accesses.
// - Full stalled pipeline makes a further memory instruction stall issue.
// - Double load and exchange hold stage 2 two clocks, two bus transactions.
// - Exchange waits until other units are idle and stages 1 and 0 hold no access; an access in stage 2 may still be moving on.
// - Double store holds decode two clocks, stalling issue at least one clock; here a double store is taken in one clock as a single access, with no stall.
// - Double store halves checked and issued separately, may be split apart.
// - An exception between double store halves requires rerunning both halves.
// - Bus waits stall only the data pipeline, not other units.
// - Memory waits count in reply phase and extend latency clock for clock.
`timescale 1ns/1ps
`include "dump_consts.svh"
module dump_top #(
    parameter int DATA_W = `DUMP_DATA_W,
    parameter int ADDR_W = `DUMP_ADDR_W,
    parameter int REG_W = `DUMP_REG_W
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic issue_valid_i,
    input wire dump_pkg::dump_op_e issue_op_i,
    input wire logic issue_double_i,
    input wire logic [REG_W-1:0] issue_dest_i,
    input wire logic [ADDR_W-1:0] issue_base_i,
    input wire logic [ADDR_W-1:0] issue_offset_i,
    input wire logic others_idle_i,
    input wire logic dbus_ready_i,
    input wire logic [DATA_W-1:0] dbus_rdata_i,
    input wire logic wb_grant_i,
    input wire logic [DATA_W-1:0] src_data_i,
    input wire logic flush_i,
    output logic issue_stall_o,
    output logic sb_set_o,
    output logic [REG_W-1:0] sb_reg_o,
    output logic src_fetch_o,
    output logic dbus_req_o,
    output logic dbus_write_o,
    output logic [ADDR_W-1:0] dbus_addr_o,
    output logic [DATA_W-1:0] dbus_wdata_o,
    output logic wb_req_o,
    output logic [REG_W-1:0] wb_reg_o,
    output logic [DATA_W-1:0] wb_data_o
);
    typedef struct packed {
        logic v;
        dump_pkg::dump_op_e op;
        logic [REG_W-1:0] rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic has_data;
        logic first;
    } dump_slot_s;

    function automatic logic dump_writes_reg(input dump_pkg::dump_op_e op);
        return op == dump_pkg::DUMP_OP_LOAD || op == dump_pkg::DUMP_OP_XCHG;
    endfunction

    dump_slot_s s2_q, s2_d, s1_q, s1_d, s0_q, s0_d;
    logic half_q, half_d;
    logic stall_q, stall_d, sb_q, sb_d, src_q, src_d;
    logic [REG_W-1:0] sbr_q, sbr_d;
    logic wbr_q, wbr_d;
    logic [REG_W-1:0] wbreg_q, wbreg_d;
    logic [DATA_W-1:0] wbdat_q, wbdat_d;
    logic adv0, adv1, adv2, take, s2_done, s0_fin, need_two, s0_wb;
    logic [ADDR_W-1:0] ea;

    always_comb
    begin
        ea = issue_base_i + issue_offset_i;
        need_two = issue_double_i || issue_op_i == dump_pkg::DUMP_OP_XCHG;
        // Reply phase completes only on ready, so waits stretch it cycle for cycle; a load-address finishes at once.
        s0_fin = s0_q.v && (s0_q.op == dump_pkg::DUMP_OP_LADDR || dbus_ready_i);
        // A load result may leave stage 0 only when its writeback is granted or a latch is free.
        adv0 = !s0_q.v || (s0_fin && (!dump_writes_reg(s0_q.op) || s0_q.has_data == 1'b0 || wb_grant_i));
        // An exchange writes back once, after its write half, with the word that its read half fetched.
        s0_wb = s0_fin && dump_writes_reg(s0_q.op)
            && !(s0_q.op == dump_pkg::DUMP_OP_XCHG && s0_q.first);
        adv1 = !s1_q.v || adv0;
        s2_done = !half_q;
        adv2 = !s2_q.v || (adv1 && s2_done);
        // Exchange waits for empty stages 1 and 0 and idle peers before it starts; stage 2 may still hold an access.
        take = issue_valid_i && adv2 && !flush_i
            && (issue_op_i != dump_pkg::DUMP_OP_XCHG || (others_idle_i && !s1_q.v && !s0_q.v));
        stall_d = issue_valid_i && !take;
        s2_d = s2_q;
        s1_d = s1_q;
        s0_d = s0_q;
        half_d = half_q;
        if (adv0)
        begin
            s0_d = s1_q;
            s0_d.v = s1_q.v && adv1;
            if (s0_fin && s0_q.op == dump_pkg::DUMP_OP_XCHG && s0_q.first)
            begin
                // The read word rides along with the write half until its writeback.
                s0_d.data = dbus_rdata_i;
                s0_d.has_data = 1'b1;
            end
        end
        else if (s0_fin && dump_writes_reg(s0_q.op) && !s0_q.has_data)
        begin
            s0_d.data = dbus_rdata_i;
            s0_d.has_data = 1'b1;
        end
        if (adv1)
        begin
            s1_d = s2_q;
            // Both halves of a split access pass on, so each half gets its own bus transaction.
            s1_d.v = s2_q.v;
        end
        if (s2_q.v && half_q && adv1)
        begin
            // Second transaction of a double load or exchange keeps stage 2 busy one more clock.
            half_d = 1'b0;
            s1_d.first = 1'b1;
            s2_d.addr = s2_q.addr + ADDR_W'(4);
        end
        else if (adv2)
        begin
            s2_d.v = take;
            s2_d.op = issue_op_i;
            s2_d.rd = issue_dest_i;
            s2_d.addr = ea;
            s2_d.data = src_data_i;
            s2_d.has_data = 1'b0;
            s2_d.first = 1'b0;
            half_d = take && need_two && issue_op_i != dump_pkg::DUMP_OP_STORE;
        end
        // Store halves arrive as separate single issues; a flush drops only unstarted work.
        if (flush_i && !half_q)
        begin
            s2_d.v = s2_q.v && !adv2;
        end
        sb_d = take && dump_writes_reg(issue_op_i);
        sbr_d = issue_dest_i;
        src_d = take && !dump_writes_reg(issue_op_i);
        wbr_d = 1'b0;
        wbreg_d = wbreg_q;
        wbdat_d = wbdat_q;
        // Stage 0 alone raises writeback, from its latch or straight from the bus reply.
        if (s0_wb)
        begin
            wbr_d = 1'b1;
            wbreg_d = s0_q.rd;
            wbdat_d = s0_q.has_data ? s0_q.data : dbus_rdata_i;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            s2_q <= '0;
            s1_q <= '0;
            s0_q <= '0;
            half_q <= 1'b0;
            stall_q <= 1'b0;
            sb_q <= 1'b0;
            sbr_q <= '0;
            src_q <= 1'b0;
            wbr_q <= 1'b0;
            wbreg_q <= '0;
            wbdat_q <= '0;
        end
        else
        begin
            s2_q <= s2_d;
            s1_q <= s1_d;
            s0_q <= s0_d;
            half_q <= half_d;
            stall_q <= stall_d;
            sb_q <= sb_d;
            sbr_q <= sbr_d;
            src_q <= src_d;
            wbr_q <= wbr_d;
            wbreg_q <= wbreg_d;
            wbdat_q <= wbdat_d;
        end
    end

    // Bus pins are registered from the next stage 1 contents so address phase sits in that stage.
    logic req_q, wr_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdat_q;
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            req_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= '0;
            wdat_q <= '0;
        end
        else
        begin
            req_q <= s1_d.v && s1_d.op != dump_pkg::DUMP_OP_LADDR;
            // An exchange reads in its first transaction and writes in its second.
            wr_q <= s1_d.op == dump_pkg::DUMP_OP_STORE || (s1_d.op == dump_pkg::DUMP_OP_XCHG && !s1_d.first);
            addr_q <= s1_d.addr;
            wdat_q <= s1_d.data;
        end
    end

    assign issue_stall_o = stall_q;
    assign sb_set_o = sb_q;
    assign sb_reg_o = sbr_q;
    assign src_fetch_o = src_q;
    assign dbus_req_o = req_q;
    assign dbus_write_o = wr_q;
    assign dbus_addr_o = addr_q;
    assign dbus_wdata_o = wdat_q;
    assign wb_req_o = wbr_q;
    assign wb_reg_o = wbreg_q;
    assign wb_data_o = wbdat_q;

    a_sb_after_take: assert property (@(posedge mclk_i) disable iff (rst_i)
        take && dump_writes_reg(issue_op_i) |=> sb_set_o && sb_reg_o == $past(issue_dest_i))
        else $error("Scoreboard set missing after load issue.");
    a_src_no_sb: assert property (@(posedge mclk_i) disable iff (rst_i)
        src_fetch_o |-> !sb_set_o)
        else $error("Store set a scoreboard bit.");
    a_stall_full: assert property (@(posedge mclk_i) disable iff (rst_i)
        issue_valid_i && s2_q.v && !adv2 |=> issue_stall_o)
        else $error("Busy pipe did not stall issue.");
    a_xchg_sync: assert property (@(posedge mclk_i) disable iff (rst_i)
        take && issue_op_i == dump_pkg::DUMP_OP_XCHG |-> others_idle_i && !s0_q.v)
        else $error("Exchange started before drain.");
    a_double_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
        half_q && s2_q.v |-> !adv2)
        else $error("Double left stage 2 early.");
    a_wait_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
        s0_q.v && s0_q.op != dump_pkg::DUMP_OP_LADDR && !dbus_ready_i && !s0_q.has_data |=> $stable(s0_q.rd))
        else $error("Reply stage moved during a wait.");
    a_wb_after_reply: assert property (@(posedge mclk_i) disable iff (rst_i)
        s0_wb |=> wb_req_o && wb_reg_o == $past(s0_q.rd))
        else $error("Writeback request missing after reply.");
    a_bus_from_s1: assert property (@(posedge mclk_i) disable iff (rst_i)
        dbus_req_o |-> s1_q.v)
        else $error("Bus request without stage 1 access.");

    sequence seq_single_take;
        take && !need_two;
    endsequence
    sequence seq_stage1_moves;
        adv1;
    endsequence
    sequence seq_reply_wait;
        s0_q.v && s0_q.op != dump_pkg::DUMP_OP_LADDR && !dbus_ready_i;
    endsequence

    a_addr_phase_next: assert property (@(posedge mclk_i) disable iff (rst_i)
        seq_single_take ##1 seq_stage1_moves |=> s1_q.v && (dbus_req_o || s1_q.op == dump_pkg::DUMP_OP_LADDR))
        else $error("Access did not reach the address phase.");
    a_reply_no_wb: assert property (@(posedge mclk_i) disable iff (rst_i)
        seq_reply_wait |=> !wb_req_o)
        else $error("Writeback requested during a wait.");
    a_wb_from_reply: assert property (@(posedge mclk_i) disable iff (rst_i)
        wb_req_o |-> $past(s0_wb))
        else $error("Writeback request without a finished reply.");
    a_laddr_no_bus: assert property (@(posedge mclk_i) disable iff (rst_i)
        s1_q.v && s1_q.op == dump_pkg::DUMP_OP_LADDR |-> !dbus_req_o)
        else $error("Load-address used the data bus.");
    a_xchg_read_first: assert property (@(posedge mclk_i) disable iff (rst_i)
        dbus_req_o && s1_q.op == dump_pkg::DUMP_OP_XCHG && s1_q.first |-> !dbus_write_o)
        else $error("Exchange did not read first.");
    a_store_writes: assert property (@(posedge mclk_i) disable iff (rst_i)
        dbus_req_o && s1_q.op == dump_pkg::DUMP_OP_STORE |-> dbus_write_o)
        else $error("Store issued as a read.");
    a_double_split: assert property (@(posedge mclk_i) disable iff (rst_i)
        s2_q.v && half_q && adv1 |=> s1_q.v && s1_q.first && s2_q.v && !half_q
            && s2_q.addr == $past(s2_q.addr) + ADDR_W'(4))
        else $error("Double access did not split into two words.");
    a_latch_keep: assert property (@(posedge mclk_i) disable iff (rst_i)
        s0_q.v && s0_q.has_data && !adv0 |=> s0_q.has_data && $stable(s0_q.data))
        else $error("Writeback latch lost its result.");
    a_stall_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
        !issue_valid_i |=> !issue_stall_o)
        else $error("Stall without an offered instruction.");
    a_store_fetch: assert property (@(posedge mclk_i) disable iff (rst_i)
        take && issue_op_i == dump_pkg::DUMP_OP_STORE |=> src_fetch_o && !sb_set_o)
        else $error("Store did not fetch its source.");
    a_flush_drop: assert property (@(posedge mclk_i) disable iff (rst_i)
        flush_i |=> !sb_set_o && !src_fetch_o)
        else $error("Flushed instruction was started.");
    a_xchg_one_wb: assert property (@(posedge mclk_i) disable iff (rst_i)
        s0_fin && s0_q.op == dump_pkg::DUMP_OP_XCHG && s0_q.first |=> !wb_req_o)
        else $error("Exchange wrote back after its read half.");
    a_take_fills_s2: assert property (@(posedge mclk_i) disable iff (rst_i)
        take |=> s2_q.v)
        else $error("Taken instruction missing from stage 2.");
    a_src_pulse: assert property (@(posedge mclk_i) disable iff (rst_i)
        src_fetch_o |=> !src_fetch_o || $past(take))
        else $error("Source fetch held without a new store.");
    a_stall_no_sb: assert property (@(posedge mclk_i) disable iff (rst_i)
        issue_stall_o |-> !sb_set_o)
        else $error("Refused instruction set a scoreboard bit.");
endmodule // dump_top

/* File: tb/dump_mem.sv */
`timescale 1ns/1ps
module dump_mem #(
    parameter logic [31:0] MIX = 32'h5A5A_0000
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [3:0] waits_i,
    input wire logic req_i,
    input wire logic [31:0] addr_i,
    output logic ready_o,
    output logic [31:0] rdata_o
);
    logic busy_q;
    logic [3:0] n_q;
    logic [31:0] a_q;
    logic take;
    // Wait cycles are spent in the reply phase of the captured access.
    assign ready_o = busy_q && (n_q >= waits_i);
    // Outside a reply the data lines toggle, so stale data never looks valid.
    assign rdata_o = ready_o ? (a_q ^ MIX) : ~(a_q ^ MIX);
    // The next address phase is accepted in the clock that ends a reply.
    assign take = req_i && (!busy_q || ready_o);
    always_ff @(posedge mclk_i)
    begin
        n_q <= n_q + 4'h1;
        if (rst_i)
            busy_q <= 1'h0;
        else if (take)
        begin
            busy_q <= 1'h1;
            a_q <= addr_i;
            n_q <= 4'h0;
        end
        else if (ready_o)
            busy_q <= 1'h0;
    end
endmodule // dump_mem

/* File: tb/test_dump_top.sv */
`timescale 1ns/1ps
`include "dump_consts.svh"
module test_dump_top;
    localparam logic [31:0] MIX = 32'h5A5A_0000;
    logic mclk_i = 1'h0, rst_i = 1'h1, issue_valid_i = 1'h0, issue_double_i = 1'h0;
    logic others_idle_i = 1'h1, wb_grant_i = 1'h1, flush_i = 1'h0, dbus_ready_i;
    dump_pkg::dump_op_e issue_op_i = dump_pkg::DUMP_OP_LOAD;
    logic [4:0] issue_dest_i = 5'h0, sb_reg_o, wb_reg_o;
    logic [31:0] issue_base_i = 32'h0, issue_offset_i = 32'h14, src_data_i = 32'h0;
    logic [31:0] dbus_rdata_i, dbus_addr_o, dbus_wdata_o, wb_data_o;
    logic issue_stall_o, sb_set_o, src_fetch_o, dbus_req_o, dbus_write_o, wb_req_o;
    logic [3:0] waits = 4'h0;
    int cyc = 0, t0, err_total = 0, num_checks = 0;
    int sb_t[$], sf_t[$], rq_t[$], wb_t[$], sb_r[$];
    logic [31:0] rq_a[$], rq_d[$], wb_d[$], wb_r[$], rq_w[$];
    always #12.5 mclk_i = ~mclk_i;
    dump_top u_dump_top (.mclk_i, .rst_i, .issue_valid_i, .issue_op_i, .issue_double_i, .issue_dest_i,
        .issue_base_i, .issue_offset_i, .others_idle_i, .dbus_ready_i, .dbus_rdata_i, .wb_grant_i,
        .src_data_i, .flush_i, .issue_stall_o, .sb_set_o, .sb_reg_o, .src_fetch_o, .dbus_req_o,
        .dbus_write_o, .dbus_addr_o, .dbus_wdata_o, .wb_req_o, .wb_reg_o, .wb_data_o);
    dump_mem #(.MIX(MIX)) u_dump_mem (.mclk_i, .rst_i, .waits_i(waits), .req_i(dbus_req_o),
        .addr_i(dbus_addr_o), .ready_o(dbus_ready_i), .rdata_o(dbus_rdata_i));
    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        if (sb_set_o === 1'h1) sb_t.push_back(cyc);
        if (sb_set_o === 1'h1) sb_r.push_back(int'(sb_reg_o));
        if (src_fetch_o === 1'h1) sf_t.push_back(cyc);
        if (u_dump_mem.take === 1'h1)
        begin
            rq_t.push_back(cyc); rq_a.push_back(dbus_addr_o);
            rq_w.push_back(32'(dbus_write_o)); rq_d.push_back(dbus_wdata_o);
        end
        if (wb_req_o === 1'h1)
        begin
            wb_t.push_back(cyc); wb_d.push_back(wb_data_o); wb_r.push_back(32'(wb_reg_o));
        end
    end
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e)
        begin
            err_total++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task automatic clr;
        sb_t.delete(); sf_t.delete(); rq_t.delete(); wb_t.delete(); sb_r.delete();
        rq_a.delete(); rq_d.delete(); rq_w.delete(); wb_d.delete(); wb_r.delete();
    endtask
    // A refused offer shows as stall in the following cycle, so the offer is held until it clears.
    task automatic issue(input dump_pkg::dump_op_e o, input logic d, input logic [31:0] b, input logic [4:0] r);
        int i;
        issue_op_i = o; issue_double_i = d; issue_base_i = b; issue_dest_i = r; issue_valid_i = 1'h1;
        for (i = 0; i < 30; i++)
        begin
            @(posedge mclk_i); #1;
            if (issue_stall_o === 1'h0) break;
        end
        if (i == 30) begin err_total++; complete_run(); end
        t0 = cyc;
    endtask
    task automatic wait_wb(input int n);
        int i;
        issue_valid_i = 1'h0;
        for (i = 0; i < 60 && wb_t.size() < n; i++)
            @(posedge mclk_i) #1;
        if (i == 60) begin err_total++; complete_run(); end
    endtask
    task automatic sc_load(input logic [3:0] w);
        waits = w; clr(); issue(dump_pkg::DUMP_OP_LOAD, 1'h0, 32'h100, 5'h05); wait_wb(1);
        chk(sb_t[0], t0);
        chk(sb_r[0], 32'h05);
        chk(rq_t[0], t0 + 1);
        chk(rq_a[0], 32'h114);
        chk(rq_w[0], 32'h0);
        chk(wb_t[0], t0 + 3 + w);
        chk(wb_d[0], 32'h114 ^ MIX);
        chk(wb_r[0], 32'h05);
    endtask
    task automatic sc_nolo(input dump_pkg::dump_op_e o);
        waits = 4'h0; clr(); src_data_i = 32'hC0DE_0001; issue(o, 1'h0, 32'h200, 5'h07);
        issue_valid_i = 1'h0; repeat (6) @(posedge mclk_i); #1;
        chk(sf_t[0], t0);
        chk(sb_t.size(), 0);
        chk(rq_t.size(), 32'(o == dump_pkg::DUMP_OP_STORE));
        if (o == dump_pkg::DUMP_OP_STORE) chk(rq_d[0], 32'hC0DE_0001);
        if (o == dump_pkg::DUMP_OP_STORE) chk(rq_w[0], 32'h1);
    endtask
    task automatic sc_b2b(input logic [3:0] w);
        int f;
        waits = w; clr(); issue(dump_pkg::DUMP_OP_LOAD, 1'h0, 32'h100, 5'h01); f = t0;
        issue(dump_pkg::DUMP_OP_LOAD, 1'h0, 32'h200, 5'h02);
        issue(dump_pkg::DUMP_OP_LOAD, 1'h0, 32'h300, 5'h03);
        issue(dump_pkg::DUMP_OP_LOAD, 1'h0, 32'h400, 5'h04); wait_wb(4);
        chk(rq_t[2] - rq_t[0], 2 * (w + 1));
        chk(wb_r[1], 32'h02);
        if (w == 0) chk(t0 - f, 3);
        else chk(t0 - f > 3, 1);
    endtask
    task automatic sc_dbl;
        waits = 4'h0; clr(); issue(dump_pkg::DUMP_OP_LOAD, 1'h1, 32'h300, 5'h09); wait_wb(2);
        chk(rq_a[1], 32'h318);
        chk(wb_t[1], t0 + 4);
        chk(wb_r[1], 32'h09);
    endtask
    task automatic sc_xchg;
        waits = 4'h0; clr(); others_idle_i = 1'h0; issue_op_i = dump_pkg::DUMP_OP_XCHG; issue_valid_i = 1'h1;
        repeat (3) @(posedge mclk_i); #1;
        chk(issue_stall_o, 1'h1);
        others_idle_i = 1'h1; issue(dump_pkg::DUMP_OP_XCHG, 1'h0, 32'h400, 5'h0B); wait_wb(1);
        chk(sb_t[0], t0);
        chk(rq_t.size(), 2);
        chk(rq_w[0], 32'h0);
        chk(rq_w[1], 32'h1);
        chk(wb_t[0], t0 + 4);
        chk(wb_d[0], 32'h414 ^ MIX);
    endtask
    initial
    begin
        repeat (2) @(posedge mclk_i); #1;
        rst_i = 1'h0;
        sc_load(4'h0); sc_load(4'h2); sc_nolo(dump_pkg::DUMP_OP_STORE); sc_nolo(dump_pkg::DUMP_OP_LADDR);
        sc_b2b(4'h0); sc_b2b(4'h4); sc_dbl(); sc_xchg();
        complete_run();
    end
endmodule // test_dump_top
